// [rtl/psi_top.sv]
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module psi_top (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // axi4-lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // decoder sequencing requests
  input wire logic STEP,
  input wire logic JUMP,
  input wire logic CALL,
  input wire logic EXIT,
  input wire logic IRQ_ACK,
  input wire logic [10:0] TARGET,
  input wire logic IP_LOW_WR,
  input wire logic [7:0] IP_LOW_WDATA,
  output logic [12:0] IP,
  // decoder register file access
  input wire logic FILE_RD,
  input wire logic FILE_WR,
  input wire logic [7:0] FILE_ADDR,
  input wire logic [7:0] FILE_WDATA,
  output logic [7:0] FILE_RDATA,
  output logic FILE_RVALID,
  output logic RF_RE,
  output logic RF_WE,
  output logic [8:0] RF_ADDR,
  output logic [7:0] RF_WDATA,
  input wire logic [7:0] RF_RDATA,
  // interrupt sources
  input wire logic EXTERNAL_INT_PIN,
  input wire logic TIMER_ZERO_OVF,
  input wire logic PORT_CHANGE,
  input wire logic NVM_WRITE_DONE,
  output logic IRQ_REQ
);
  // ****************************************
  // state
  // ****************************************
  logic [12:0] ip_q; // instruction pointer
  logic [4:0] hold_q; // high holding register
  logic [7:0] ictl_q; // interrupt control
  logic [7:0] ind_ptr_q; // indirect pointer
  logic bank_q; // indirect bank select, kept clear by software
  logic [12:0] stk_mem [0:psi_pkg::STK_DEPTH-1]; // return stack, no reset
  logic [2:0] sp_q; // hidden stack pointer, no bus path
  logic pin_s1_q, pin_s2_q, pin_s3_q; // external pin synchroniser and history
  logic irq_q;
  logic awr_q, bval_q, arr_q, rval_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic rf_re_q, rf_we_q, zero_rd_q, rd_pend_q, frv_q, zpend_q;
  logic [8:0] rf_addr_q;
  logic [7:0] rf_wdata_q, frd_q;

  // ****************************************
  // bus decode
  // ****************************************
  wire wr_go = CE & S_AXI_AWVALID & S_AXI_WVALID & ~awr_q & ~bval_q;
  wire wr_hs = CE & awr_q; // both channels taken together
  wire [7:0] wr_idx = S_AXI_AWADDR >> psi_pkg::ADDR_SHIFT;
  wire wr_lane = S_AXI_WSTRB[0]; // all registers sit in byte lane 0
  wire [7:0] wr_byte = S_AXI_WDATA[7:0];
  wire wr_ip_low = wr_hs & wr_lane & (wr_idx == psi_pkg::IDX_IP_LOW);
  wire wr_hold = wr_hs & wr_lane & (wr_idx == psi_pkg::IDX_IP_HOLD);
  wire wr_ictl = wr_hs & wr_lane & (wr_idx == psi_pkg::IDX_INT_CTL);
  wire wr_ptr = wr_hs & wr_lane & (wr_idx == psi_pkg::IDX_IND_PTR);
  wire wr_bank = wr_hs & wr_lane & (wr_idx == psi_pkg::IDX_BANK);
  wire wr_map = (wr_idx == psi_pkg::IDX_IP_LOW) | (wr_idx == psi_pkg::IDX_IP_HOLD) |
                (wr_idx == psi_pkg::IDX_INT_CTL) | (wr_idx == psi_pkg::IDX_IND_PTR) |
                (wr_idx == psi_pkg::IDX_BANK);
  wire rd_go = CE & S_AXI_ARVALID & ~arr_q & ~rval_q;
  wire [7:0] rd_idx = S_AXI_ARADDR >> psi_pkg::ADDR_SHIFT;
  // upper pointer bits and stack pointer have no read path
  wire [7:0] rd_byte = (rd_idx == psi_pkg::IDX_IP_LOW) ? ip_q[7:0] :
                       (rd_idx == psi_pkg::IDX_IP_HOLD) ? {3'h0, hold_q} :
                       (rd_idx == psi_pkg::IDX_INT_CTL) ? ictl_q :
                       (rd_idx == psi_pkg::IDX_IND_PTR) ? ind_ptr_q :
                       (rd_idx == psi_pkg::IDX_BANK) ? {bank_q, 7'h00} : psi_pkg::ZERO_BYTE;
  wire rd_map = (rd_idx == psi_pkg::IDX_IP_LOW) | (rd_idx == psi_pkg::IDX_IP_HOLD) |
                (rd_idx == psi_pkg::IDX_INT_CTL) | (rd_idx == psi_pkg::IDX_IND_PTR) |
                (rd_idx == psi_pkg::IDX_BANK);

  // ****************************************
  // bus handshakes
  // ****************************************
  // write: ready pulses one cycle once both channels wait, response follows
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      awr_q <= 1'b0;
      bval_q <= 1'b0;
      bresp_q <= psi_pkg::RESP_OKAY;
    end else if (CE) begin
      awr_q <= wr_go;
      if (awr_q) begin
        bval_q <= 1'b1;
        bresp_q <= wr_map ? psi_pkg::RESP_OKAY : psi_pkg::RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bval_q <= 1'b0;
      end
    end
  end

  // read: address taken, data one cycle later, held until rready
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      arr_q <= 1'b0;
      rval_q <= 1'b0;
      rresp_q <= psi_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (CE) begin
      arr_q <= rd_go;
      if (arr_q) begin
        rval_q <= 1'b1;
        rdata_q <= {24'h00_0000, rd_byte};
        rresp_q <= rd_map ? psi_pkg::RESP_OKAY : psi_pkg::RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
        rval_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // instruction pointer and stack
  // ****************************************
  wire do_push = CALL | IRQ_ACK;
  wire [2:0] sp_dn = sp_q - 3'h1;
  // page bits come from holding 4:3, the low 11 from the target
  wire [12:0] branch_ip = {hold_q[4:3], TARGET};
  wire [12:0] low_wr_ip_d = {hold_q, IP_LOW_WDATA};
  wire [12:0] bus_wr_ip_d = {hold_q, wr_byte};
  // priority: exit, interrupt vector, call/jump, decoder low write, bus low write, step
  wire [12:0] ip_d = EXIT ? stk_mem[sp_dn] :
                     IRQ_ACK ? psi_pkg::IRQ_VECTOR :
                     (CALL | JUMP) ? branch_ip :
                     IP_LOW_WR ? low_wr_ip_d :
                     wr_ip_low ? bus_wr_ip_d :
                     STEP ? ip_q + 13'h0001 : ip_q;

  // pointer register, reset to zero
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ip_q <= psi_pkg::IP_RST;
    end else if (CE) begin
      ip_q <= ip_d;
    end
  end

  // holding register only changes by a bus write, never by push/pop
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      hold_q <= psi_pkg::HOLD_RST;
    end else if (CE && wr_hold) begin
      hold_q <= wr_byte[4:0];
    end
  end

  // circular stack: pointer wraps in three bits, no overflow status
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      sp_q <= 3'h0;
    end else if (CE) begin
      if (EXIT) begin
        sp_q <= sp_dn;
      end else if (do_push) begin
        sp_q <= sp_q + 3'h1;
      end
    end
  end

  // entries hold the return address, contents undefined after reset
  always_ff @(posedge REF_CLK) begin
    if (CE && do_push && !EXIT) begin
      stk_mem[sp_q] <= ip_q;
    end
  end

  // ****************************************
  // interrupt control
  // ****************************************
  // pin passes two flops, the third only feeds edge detection
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      pin_s1_q <= 1'b0;
      pin_s2_q <= 1'b0;
      pin_s3_q <= 1'b0;
    end else if (CE) begin
      pin_s1_q <= EXTERNAL_INT_PIN;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
    end
  end

  wire ext_evt = pin_s2_q & ~pin_s3_q; // rising edge of the pin
  wire [7:0] ictl_wr = wr_ictl ? wr_byte : ictl_q;
  // timer, pin and port events set flags whatever the enables say; set beats a same-cycle clear
  wire [7:0] ictl_d = {ictl_wr[7:3],
                       ictl_wr[psi_pkg::BIT_T0_FLAG] | TIMER_ZERO_OVF,
                       ictl_wr[psi_pkg::BIT_EXT_FLAG] | ext_evt,
                       ictl_wr[psi_pkg::BIT_PORT_FLAG] | PORT_CHANGE};
  wire src_t0 = ictl_q[psi_pkg::BIT_T0_EN] & ictl_q[psi_pkg::BIT_T0_FLAG];
  wire src_ext = ictl_q[psi_pkg::BIT_EXT_EN] & ictl_q[psi_pkg::BIT_EXT_FLAG];
  wire src_port = ictl_q[psi_pkg::BIT_PORT_EN] & ictl_q[psi_pkg::BIT_PORT_FLAG];
  wire src_nvm = ictl_q[psi_pkg::BIT_NVM_EN] & NVM_WRITE_DONE;
  wire irq_d = ictl_q[psi_pkg::BIT_GLOBAL] & (src_t0 | src_ext | src_port | src_nvm);

  // control register and request output
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ictl_q <= psi_pkg::INT_CTL_RST;
      irq_q <= 1'b0;
    end else if (CE) begin
      ictl_q <= ictl_d;
      irq_q <= irq_d;
    end
  end

  // ****************************************
  // indirect access
  // ****************************************
  wire ind_hit = (FILE_ADDR == psi_pkg::IDX_IND_PORT);
  wire ptr_self = (ind_ptr_q == psi_pkg::IDX_IND_PORT); // points at the port itself
  wire [8:0] eff_addr = ind_hit ? {bank_q, ind_ptr_q} : {1'b0, FILE_ADDR};
  wire self_acc = ind_hit & ptr_self;

  // pointer and bank holders
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ind_ptr_q <= psi_pkg::IND_PTR_RST;
      bank_q <= 1'b0;
    end else if (CE) begin
      if (wr_ptr) begin
        ind_ptr_q <= wr_byte;
      end
      if (wr_bank) begin
        bank_q <= wr_byte[psi_pkg::BIT_BANK];
      end
    end
  end

  // file request stage: self-addressed write is dropped, read forced to zero
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rf_re_q <= 1'b0;
      rf_we_q <= 1'b0;
      rf_addr_q <= 9'h000;
      rf_wdata_q <= 8'h00;
      zero_rd_q <= 1'b0;
    end else if (CE) begin
      rf_re_q <= FILE_RD & ~self_acc;
      rf_we_q <= FILE_WR & ~self_acc;
      rf_addr_q <= eff_addr;
      rf_wdata_q <= FILE_WDATA;
      zero_rd_q <= FILE_RD & self_acc;
    end
  end

  // answer stage: data from the file one cycle after the strobe
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      rd_pend_q <= 1'b0;
      zpend_q <= 1'b0;
      frv_q <= 1'b0;
      frd_q <= 8'h00;
    end else if (CE) begin
      rd_pend_q <= rf_re_q | zero_rd_q;
      zpend_q <= zero_rd_q; // self read rides along, file data ignored
      frv_q <= rd_pend_q;
      if (rd_pend_q) begin
        frd_q <= zpend_q ? psi_pkg::ZERO_BYTE : RF_RDATA;
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign S_AXI_AWREADY = awr_q;
  assign S_AXI_WREADY = awr_q;
  assign S_AXI_BVALID = bval_q;
  assign S_AXI_BRESP = bresp_q;
  assign S_AXI_ARREADY = arr_q;
  assign S_AXI_RVALID = rval_q;
  assign S_AXI_RRESP = rresp_q;
  assign S_AXI_RDATA = rdata_q;
  assign IP = ip_q;
  assign IRQ_REQ = irq_q;
  assign RF_RE = rf_re_q;
  assign RF_WE = rf_we_q;
  assign RF_ADDR = rf_addr_q;
  assign RF_WDATA = rf_wdata_q;
  assign FILE_RDATA = frd_q;
  assign FILE_RVALID = frv_q;

  // ****************************************
  // checks
  // ****************************************
  AST_GATE_OFF: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && !ictl_q[7] |=> !IRQ_REQ) else $error("request without global gate");
  AST_T0_REQ: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && ictl_q[7] && ictl_q[5] && ictl_q[2] |=> IRQ_REQ) else $error("timer request missing");
  AST_EXT_FLAG: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && ext_evt |=> ictl_q[1]) else $error("pin flag not set");
  AST_T0_SET: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && TIMER_ZERO_OVF |=> ictl_q[2]) else $error("timer flag lost");
  AST_STICKY: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && ictl_q[0] && !wr_ictl |=> ictl_q[0]) else $error("flag dropped");
  AST_HOLD_ONLY: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && wr_hold && !STEP && !JUMP && !CALL && !EXIT && !IRQ_ACK && !IP_LOW_WR |=> $stable(IP))
    else $error("holding write moved pointer");
  AST_JUMP: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && JUMP && !EXIT && !IRQ_ACK |=> IP == {$past(hold_q[4:3]), $past(TARGET)})
    else $error("jump target wrong");
  AST_CALL_RET: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && CALL && !EXIT && !IRQ_ACK ##1 CE && EXIT |=> IP == $past(IP, 2))
    else $error("return address wrong");
  AST_HOLD_KEEP: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && (EXIT || CALL) && !wr_hold |=> $stable(hold_q)) else $error("holding disturbed");
  AST_SELF_WR: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && FILE_WR && self_acc |=> !RF_WE) else $error("self write stored");
  AST_SELF_RD: assert property (@(posedge REF_CLK) disable iff (RST)
    CE && FILE_RD && self_acc ##1 CE ##1 CE |=> FILE_RVALID && FILE_RDATA == 8'h00)
    else $error("self read not zero");
  CVR_CALL_RET: cover property (@(posedge REF_CLK) disable iff (RST) CALL ##[1:8] EXIT);
  CVR_IRQ: cover property (@(posedge REF_CLK) disable iff (RST) $rose(IRQ_REQ));
  CVR_IND_RD: cover property (@(posedge REF_CLK) disable iff (RST) FILE_RD && ind_hit && !ptr_self);
endmodule // psi_top
`default_nettype wire

// [rtl/psi_pkg.sv]
// ****************************************
// constants for the sequencing block
// ****************************************
package psi_pkg;
  // register indices on the bus, byte address is four times the index
  localparam logic [7:0] IDX_IND_PORT = 8'h00; // indirect access port, no storage
  localparam logic [7:0] IDX_IP_LOW = 8'h02; // instruction pointer low byte
  localparam logic [7:0] IDX_BANK = 8'h03; // indirect bank select holder
  localparam logic [7:0] IDX_IND_PTR = 8'h04; // indirect pointer
  localparam logic [7:0] IDX_IP_HOLD = 8'h0A; // instruction pointer high holding
  localparam logic [7:0] IDX_INT_CTL = 8'h0B; // interrupt control
  localparam int ADDR_SHIFT = 2; // word aligned registers
  // interrupt control field positions
  localparam int BIT_GLOBAL = 7;
  localparam int BIT_NVM_EN = 6;
  localparam int BIT_T0_EN = 5;
  localparam int BIT_EXT_EN = 4;
  localparam int BIT_PORT_EN = 3;
  localparam int BIT_T0_FLAG = 2;
  localparam int BIT_EXT_FLAG = 1;
  localparam int BIT_PORT_FLAG = 0;
  localparam int BIT_BANK = 7; // bank select position in its holder
  // widths
  localparam int IP_W = 13;
  localparam int TGT_W = 11;
  localparam int HOLD_W = 5;
  localparam int STK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int RF_AW = 9;
  // reset values
  localparam logic [IP_W-1:0] IP_RST = 13'h0000;
  localparam logic [HOLD_W-1:0] HOLD_RST = 5'h00;
  localparam logic [7:0] INT_CTL_RST = 8'h00;
  localparam logic [7:0] IND_PTR_RST = 8'h00;
  localparam logic [IP_W-1:0] IRQ_VECTOR = 13'h0000; // plain default entry point
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : psi_pkg

// [dv/psi_rf_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// register file seen through the file strobes
// ****************************************
module psi_rf_model (
  input wire logic clk,
  input wire logic rf_re,
  input wire logic rf_we,
  input wire logic [8:0] rf_addr,
  input wire logic [7:0] rf_wdata,
  output logic [7:0] rf_rdata
);
  logic [7:0] mem [0:511]; // storage behind the indirect port
  initial begin
    rf_rdata = 8'hA5;
    for (int i = 0; i < 512; i++) mem[i] = 8'h00;
  end
  // data valid only the cycle after a read strobe; otherwise it toggles
  // so that a late sample never looks like a good value
  always @(posedge clk) begin
    if (rf_we) mem[rf_addr] <= rf_wdata;
    if (rf_re) rf_rdata <= mem[rf_addr];
    else rf_rdata <= ~rf_rdata;
  end
endmodule // psi_rf_model
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clk = 1'h0, rst = 1'h1, ce = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ipld = 8'h00, faddr = 8'h00, fwd = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, rdata, r;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, frvalid, rf_re, rf_we, irq;
  logic [1:0] bresp, rresp;
  logic step = 1'h0, jump = 1'h0, call = 1'h0, exit_r = 1'h0, ack = 1'h0, iplwr = 1'h0;
  logic frd = 1'h0, fwr = 1'h0, pin = 1'h0, t0ovf = 1'h0, pchg = 1'h0, nvm = 1'h0;
  logic [10:0] tgt = 11'h000;
  logic [12:0] ip, mip; // mip: expected pointer
  logic [12:0] stk [0:7]; // expected stack contents
  logic [7:0] frdata, rf_wdata, rf_rdata, q;
  logic [8:0] rf_addr, last_ra;
  logic [4:0] hold;
  integer n_mismatch = 0, comparisons = 0, n_we = 0, seed = 32'hbeaaf84d, sp = 0, k;
  always #2 clk = ~clk; // 250 MHz
  psi_top i_psi_top (.REF_CLK(clk), .RST(rst), .CE(ce),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .STEP(step), .JUMP(jump), .CALL(call), .EXIT(exit_r), .IRQ_ACK(ack), .TARGET(tgt),
    .IP_LOW_WR(iplwr), .IP_LOW_WDATA(ipld), .IP(ip), .FILE_RD(frd), .FILE_WR(fwr),
    .FILE_ADDR(faddr), .FILE_WDATA(fwd), .FILE_RDATA(frdata), .FILE_RVALID(frvalid),
    .RF_RE(rf_re), .RF_WE(rf_we), .RF_ADDR(rf_addr), .RF_WDATA(rf_wdata), .RF_RDATA(rf_rdata),
    .EXTERNAL_INT_PIN(pin), .TIMER_ZERO_OVF(t0ovf), .PORT_CHANGE(pchg),
    .NVM_WRITE_DONE(nvm), .IRQ_REQ(irq));
  psi_rf_model i_psi_rf_model (.clk(clk), .rf_re(rf_re), .rf_we(rf_we), .rf_addr(rf_addr),
    .rf_wdata(rf_wdata), .rf_rdata(rf_rdata));
  // file strobe monitor: last read address and count of writes
  always @(posedge clk) begin
    if (rf_re === 1'h1) last_ra <= rf_addr;
    if (rf_we === 1'h1) n_we <= n_we + 1;
  end
  // ****************************************
  // compare, report and bus tasks
  // ****************************************
  task final_report;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk_d(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task chk_ip(input logic [12:0] g, input logic [12:0] e);
    chk_d({19'h0, g}, {19'h0, e});
  endtask
  task chk_b(input logic g, input logic e);
    chk_d({31'h0, g}, {31'h0, e});
  endtask
  task to_fail;
    n_mismatch++;
    $display("unexpected timeout at %0t: got %h expected %h", $time, 1'h0, 1'h1);
    final_report();
  endtask
  // write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] e);
    awaddr <= a; awvalid <= 1'h1; wdata <= {24'h0, d}; wvalid <= 1'h1; bready <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (!(bvalid === 1'h1) && k < 40);
    bready <= 1'h0;
    if (k >= 40) to_fail();
    chk_d({30'h0, bresp}, {30'h0, e});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    araddr <= a; arvalid <= 1'h1; rready <= 1'h1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (!(rvalid === 1'h1) && k < 40);
    rready <= 1'h0;
    if (k >= 40) to_fail();
    chk_d(rdata, {24'h0, e});
    chk_d({30'h0, rresp}, {30'h0, er});
  endtask
  // sequencing pulse: 0 jump, 1 call, 2 exit, 3 acknowledge, 4 low write
  task automatic seq(input int kind, input logic [10:0] t, input logic [7:0] d);
    jump <= kind == 0; call <= kind == 1; exit_r <= kind == 2; ack <= kind == 3;
    iplwr <= kind == 4; tgt <= t; ipld <= d;
    @(posedge clk);
    jump <= 1'h0; call <= 1'h0; exit_r <= 1'h0; ack <= 1'h0; iplwr <= 1'h0;
    if (kind == 1 || kind == 3) begin
      stk[sp] = mip;
      sp = (sp + 1) % 8;
    end
    if (kind == 2) begin
      sp = (sp + 7) % 8;
      mip = stk[sp];
    end
    else if (kind == 3) mip = psi_pkg::IRQ_VECTOR;
    else if (kind == 4) mip = {hold, d};
    else mip = {hold[4:3], t};
    @(posedge clk);
    chk_ip(ip, mip);
  endtask
  task automatic fop(input logic rd, input logic [7:0] a, input logic [7:0] d);
    frd <= rd; fwr <= !rd; faddr <= a; fwd <= d;
    @(posedge clk);
    frd <= 1'h0; fwr <= 1'h0; k = 0; q = 8'h00;
    do begin
      @(posedge clk);
      k++;
    end while (!(frvalid === 1'h1) && k < 6);
    if (frvalid === 1'h1) q = frdata;
    if (rd && k >= 6) to_fail();
  endtask
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk);
    chk_b(irq, e);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk_ip(ip, 13'h0000);
    axi_rd(8'h2C, 8'h00, 2'h0);
    axi_rd(8'h28, 8'h00, 2'h0);
    axi_rd(8'h3C, 8'h00, 2'h2);
    axi_rd(8'h00, 8'h00, 2'h2);
    r = $random(seed);
    hold = r[4:0];
    mip = 13'h0000;
    axi_wr(8'h28, {3'h0, hold}, 2'h0);
    chk_ip(ip, mip);
    seq(4, 11'h000, r[15:8]);
    axi_rd(8'h08, r[15:8], 2'h0);
    axi_wr(8'h08, r[23:16], 2'h0);
    mip = {hold, r[23:16]};
    @(posedge clk);
    chk_ip(ip, mip);
    step <= 1'h1;
    repeat (3) @(posedge clk);
    step <= 1'h0;
    mip = mip + 13'h0003;
    @(posedge clk);
    chk_ip(ip, mip);
    // clock enable low freezes the pointer even with step held
    ce <= 1'h0;
    step <= 1'h1;
    repeat (3) @(posedge clk);
    ce <= 1'h1;
    step <= 1'h0;
    @(posedge clk);
    chk_ip(ip, mip);
    // computed jump: low byte wraps, upper bits still from holding
    seq(4, 11'h000, mip[7:0] + 8'hF0);
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      hold = r[15:11];
      axi_wr(8'h28, {3'h0, hold}, 2'h0);
      seq(0, r[10:0], 8'h00);
    end
    seq(3, 11'h000, 8'h00);
    for (int i = 0; i < 9; i++) begin
      r = $random(seed);
      seq(1, r[10:0], 8'h00);
    end
    for (int i = 0; i < 9; i++) seq(2, 11'h000, 8'h00);
    // call followed at once by an exit returns the pushed pointer
    call <= 1'h1;
    tgt <= r[10:0];
    @(posedge clk);
    call <= 1'h0;
    exit_r <= 1'h1;
    @(posedge clk);
    exit_r <= 1'h0;
    stk[sp] = mip;
    @(posedge clk);
    chk_ip(ip, mip);
    axi_rd(8'h28, {3'h0, hold}, 2'h0);
    // interrupt flags and gating
    t0ovf <= 1'h1;
    @(posedge clk);
    t0ovf <= 1'h0;
    irq_chk(1'h0);
    axi_rd(8'h2C, 8'h04, 2'h0);
    axi_wr(8'h2C, 8'hA4, 2'h0);
    irq_chk(1'h1);
    axi_wr(8'h2C, 8'h24, 2'h0);
    irq_chk(1'h0);
    axi_wr(8'h2C, 8'hA0, 2'h0);
    irq_chk(1'h0);
    pin <= 1'h1;
    repeat (6) @(posedge clk);
    pin <= 1'h0;
    axi_rd(8'h2C, 8'hA2, 2'h0);
    axi_wr(8'h2C, 8'h92, 2'h0);
    irq_chk(1'h1);
    axi_wr(8'h2C, 8'h00, 2'h0);
    pchg <= 1'h1;
    @(posedge clk);
    pchg <= 1'h0;
    axi_rd(8'h2C, 8'h01, 2'h0);
    axi_wr(8'h2C, 8'h89, 2'h0);
    irq_chk(1'h1);
    nvm <= 1'h1;
    axi_wr(8'h2C, 8'hC0, 2'h0);
    irq_chk(1'h1);
    nvm <= 1'h0;
    axi_wr(8'h2C, 8'h00, 2'h0);
    irq_chk(1'h0);
    // indirect access through the pointer
    r = $random(seed);
    fop(1'h0, 8'h25, r[7:0]);
    axi_wr(8'h10, 8'h25, 2'h0);
    fop(1'h1, 8'h00, 8'h00);
    chk_d({24'h0, q}, {24'h0, r[7:0]});
    chk_d({23'h0, last_ra}, 32'h00000025);
    axi_wr(8'h0C, 8'h80, 2'h0);
    fop(1'h0, 8'h00, r[15:8]);
    fop(1'h1, 8'h00, 8'h00);
    chk_d({24'h0, q}, {24'h0, r[15:8]});
    chk_d({23'h0, last_ra}, 32'h00000125);
    axi_wr(8'h0C, 8'h00, 2'h0);
    axi_wr(8'h10, 8'h00, 2'h0);
    r = n_we;
    fop(1'h0, 8'h00, 8'h5A);
    chk_d(n_we, r);
    fop(1'h1, 8'h00, 8'h00);
    chk_d({24'h0, q}, 32'h00000000);
    // mid-run reset clears pointer, holding and enables
    axi_wr(8'h2C, 8'hF8, 2'h0);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk_ip(ip, 13'h0000);
    axi_rd(8'h28, 8'h00, 2'h0);
    axi_rd(8'h2C, 8'h00, 2'h0);
    // byte lane 0 off: write ignored with an OKAY response, register keeps its value
    wstrb <= 4'hE;
    axi_wr(8'h28, 8'h1F, 2'h0);
    wstrb <= 4'hF;
    axi_rd(8'h28, 8'h00, 2'h0);
    axi_wr(8'h3C, 8'h00, 2'h2);
    final_report();
  end
endmodule // testbench
`default_nettype wire
